//--- rtl/asq_pkg.sv
// Functional notes
// - Code 0100: channels 0 to N, host-paced
// - Upper internal sweep stores one result per channel
// - Upper sweeps run N to top, ascending
// - Custom scans: unique ascending, sixteen conversions maximum
// - Custom channels come from the two enables
// - Internal custom scan results go to FIFO
// - Arbitrary list up to 256 entries, no averaging
// - List entries use channel-select coding, any order
// - Arbitrary list runs on host pacing only
// - Codes 1010 to 1111 keep mode, ignore low bits
// - External custom scan: host-paced, no averaging
// - Select field maps 0-15 onto inputs 0-15
// - Code 0000 keeps mode, ignores low bits
package asq_pkg;
   // Register word indexes
   localparam logic [3:0] REG_MODE = 4'h0;
   localparam logic [3:0] REG_USER_LOW = 4'h1;
   localparam logic [3:0] REG_USER_HIGH = 4'h2;
   localparam logic [3:0] REG_CONFIG = 4'h3;
   localparam logic [3:0] REG_LIST_LEN = 4'h4;
   localparam logic [3:0] REG_LIST_PTR = 4'h5;
   localparam logic [3:0] REG_LIST_DATA = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;
   localparam logic [3:0] REG_COUNT = 4'h8;
   // Mode, config and status word fields
   localparam int SCAN_MSB = 14;
   localparam int SCAN_LSB = 11;
   localparam int CHSEL_MSB = 10;
   localparam int CHSEL_LSB = 7;
   localparam int CONFIG_AVG_BIT = 0;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_CODE_LSB = 1;
   localparam int ST_CH_LSB = 5;
   // Scan codes
   localparam logic [3:0] SCAN_KEEP = 4'h0;
   localparam logic [3:0] SCAN_ZERO_EXT = 4'h4;
   localparam logic [3:0] SCAN_UPPER_INT = 4'h5;
   localparam logic [3:0] SCAN_UPPER_EXT = 4'h6;
   localparam logic [3:0] SCAN_USER_INT = 4'h7;
   localparam logic [3:0] SCAN_USER_EXT = 4'h8;
   localparam logic [3:0] SCAN_LIST_EXT = 4'h9;
   localparam logic [3:0] SCAN_KEEP_HIGH = 4'ha;
   // Reset values
   localparam logic [3:0] RST_SCAN = 4'h0;
   localparam logic [3:0] RST_CHSEL = 4'h0;
   localparam logic [7:0] RST_USER = 8'h00;
   localparam logic [7:0] RST_LIST_LEN = 8'h00;
   // Sizes
   localparam int LIST_DEPTH = 256;
   localparam int USER_MAX_CONV = 16;
   // Internal conversion pacing
   localparam int CLK_NS = 8;
   localparam int INT_CONV_NS = 64;
   localparam int INT_CONV_CYC = (INT_CONV_NS + CLK_NS - 1) / CLK_NS;
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } asq_state_e;
endpackage

//--- rtl/asq_sequencer.sv
`timescale 1ns/10ps
module asq_sequencer #(
   parameter int NUM_CH = 16,
   parameter int INT_DIV = asq_pkg::INT_CONV_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   input wire logic ext_step,
   output logic conv_start,
   output logic [3:0] conv_channel,
   output logic conv_average,
   output logic conv_to_fifo,
   output logic scan_busy,
   output logic scan_done
);
   localparam logic [3:0] TOP = 4'(NUM_CH - 1);
   localparam logic [7:0] DIV_LAST = 8'(INT_DIV - 1);

   // Keep codes leave mode and select untouched
   function automatic logic is_keep(input logic [3:0] code);
      is_keep = (code == asq_pkg::SCAN_KEEP) ||
                (code >= asq_pkg::SCAN_KEEP_HIGH);
   endfunction

   // Modes paced by the host serial clock
   function automatic logic is_ext(input logic [3:0] code);
      is_ext = (code == asq_pkg::SCAN_ZERO_EXT) ||
               (code == asq_pkg::SCAN_UPPER_EXT) ||
               (code == asq_pkg::SCAN_USER_EXT) ||
               (code == asq_pkg::SCAN_LIST_EXT);
   endfunction

   // Lowest enabled channel at or above a start point, bit 4 means none
   function automatic logic [4:0] next_set(input logic [15:0] mask,
                                           input logic [4:0] from);
      logic [4:0] res;
      res = 5'h10;
      for (int i = 15; i >= 0; i--) begin
         if (mask[i] && (5'(i) >= from) && (i < NUM_CH)) begin
            res = 5'(i);
         end
      end
      next_set = res;
   endfunction

   // Register state
   logic [3:0] scan_code;
   logic [3:0] chsel;
   logic [7:0] user_low;
   logic [7:0] user_high;
   logic avg_on;
   logic [7:0] list_len;
   logic [7:0] list_ptr;
   logic start_req;
   logic [3:0] next_scan_code;
   logic [3:0] next_chsel;
   logic [7:0] next_user_low;
   logic [7:0] next_user_high;
   logic next_avg_on;
   logic [7:0] next_list_len;
   logic [7:0] next_list_ptr;
   logic next_start_req;
   logic [15:0] next_reg_rdata;
   logic [3:0] list_mem [asq_pkg::LIST_DEPTH];

   // Sequencer state
   asq_pkg::asq_state_e state;
   asq_pkg::asq_state_e next_state;
   logic [3:0] cur_ch;
   logic [3:0] next_cur_ch;
   logic [7:0] idx;
   logic [7:0] next_idx;
   logic [8:0] conv_count;
   logic [8:0] next_conv_count;
   logic next_conv_start;
   logic [3:0] next_conv_channel;
   logic next_conv_average;
   logic next_conv_to_fifo;
   logic next_scan_busy;
   logic next_scan_done;

   // Pin synchroniser and pacing state
   logic step_s1;
   logic step_s2;
   logic step_s3;
   logic step_level;
   logic next_step_level;
   logic ext_edge;
   logic [7:0] div_cnt;
   logic [7:0] next_div_cnt;
   logic int_tick;
   logic next_int_tick;

   logic [15:0] user_mask;
   logic [3:0] new_code;
   assign user_mask = {user_high, user_low};
   assign new_code = reg_wdata[asq_pkg::SCAN_MSB:asq_pkg::SCAN_LSB];

   // Register writes and reads
   always_comb begin
      next_scan_code = scan_code;
      next_chsel = chsel;
      next_user_low = user_low;
      next_user_high = user_high;
      next_avg_on = avg_on;
      next_list_len = list_len;
      next_list_ptr = list_ptr;
      next_start_req = 1'b0;
      next_reg_rdata = 16'h0000;
      if (reg_write) begin
         unique case (reg_addr)
            asq_pkg::REG_MODE: begin
               if (!is_keep(new_code)) begin
                  next_scan_code = new_code;
                  next_chsel =
                     reg_wdata[asq_pkg::CHSEL_MSB:asq_pkg::CHSEL_LSB];
                  next_start_req = 1'b1;
               end
            end
            asq_pkg::REG_USER_LOW: next_user_low = reg_wdata[7:0];
            asq_pkg::REG_USER_HIGH: next_user_high = reg_wdata[7:0];
            asq_pkg::REG_CONFIG: begin
               next_avg_on = reg_wdata[asq_pkg::CONFIG_AVG_BIT];
            end
            asq_pkg::REG_LIST_LEN: next_list_len = reg_wdata[7:0];
            asq_pkg::REG_LIST_PTR: next_list_ptr = reg_wdata[7:0];
            asq_pkg::REG_LIST_DATA: next_list_ptr = list_ptr + 8'h01;
            default: ;
         endcase
      end
      if (reg_read) begin
         unique case (reg_addr)
            asq_pkg::REG_MODE: begin
               next_reg_rdata[asq_pkg::SCAN_MSB:asq_pkg::SCAN_LSB] =
                  scan_code;
               next_reg_rdata[asq_pkg::CHSEL_MSB:asq_pkg::CHSEL_LSB] = chsel;
            end
            asq_pkg::REG_USER_LOW: next_reg_rdata[7:0] = user_low;
            asq_pkg::REG_USER_HIGH: next_reg_rdata[7:0] = user_high;
            asq_pkg::REG_CONFIG: begin
               next_reg_rdata[asq_pkg::CONFIG_AVG_BIT] = avg_on;
            end
            asq_pkg::REG_LIST_LEN: next_reg_rdata[7:0] = list_len;
            asq_pkg::REG_LIST_PTR: next_reg_rdata[7:0] = list_ptr;
            asq_pkg::REG_LIST_DATA: next_reg_rdata[3:0] = list_mem[list_ptr];
            asq_pkg::REG_STATUS: begin
               next_reg_rdata[asq_pkg::ST_BUSY_BIT] = scan_busy;
               next_reg_rdata[asq_pkg::ST_CODE_LSB +: 4] = scan_code;
               next_reg_rdata[asq_pkg::ST_CH_LSB +: 4] = cur_ch;
            end
            asq_pkg::REG_COUNT: next_reg_rdata[8:0] = conv_count;
            default: next_reg_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         scan_code <= asq_pkg::RST_SCAN;
         chsel <= asq_pkg::RST_CHSEL;
         user_low <= asq_pkg::RST_USER;
         user_high <= asq_pkg::RST_USER;
         avg_on <= 1'b0;
         list_len <= asq_pkg::RST_LIST_LEN;
         list_ptr <= 8'h00;
         start_req <= 1'b0;
         reg_rdata <= 16'h0000;
      end else begin
         scan_code <= next_scan_code;
         chsel <= next_chsel;
         user_low <= next_user_low;
         user_high <= next_user_high;
         avg_on <= next_avg_on;
         list_len <= next_list_len;
         list_ptr <= next_list_ptr;
         start_req <= next_start_req;
         reg_rdata <= next_reg_rdata;
      end
   end

   // Arbitrary list storage, written one entry at a time
   always_ff @(posedge clk_sys) begin
      if (reg_write && (reg_addr == asq_pkg::REG_LIST_DATA)) begin
         list_mem[list_ptr] <= reg_wdata[3:0];
      end
   end

   // Host step pin: three stages, level taken when two and three agree
   always_comb begin
      next_step_level = step_level;
      if (step_s2 == step_s3) begin
         next_step_level = step_s3;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         step_s1 <= 1'b0;
         step_s2 <= 1'b0;
         step_s3 <= 1'b0;
         step_level <= 1'b0;
      end else begin
         step_s1 <= ext_step;
         step_s2 <= step_s1;
         step_s3 <= step_s2;
         step_level <= next_step_level;
      end
   end

   assign ext_edge = next_step_level && !step_level;

   // Internal conversion clock divider
   always_comb begin
      next_int_tick = 1'b0;
      next_div_cnt = div_cnt + 8'h01;
      if (div_cnt == DIV_LAST) begin
         next_div_cnt = 8'h00;
         next_int_tick = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_cnt <= 8'h00;
         int_tick <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         int_tick <= next_int_tick;
      end
   end

   // Channel sequencer
   always_comb begin
      logic [4:0] first_user;
      logic [4:0] succ_user;
      logic pace;
      logic last;
      first_user = next_set(user_mask, 5'h00);
      succ_user = next_set(user_mask, {1'b0, cur_ch} + 5'h01);
      pace = is_ext(scan_code) ? ext_edge : int_tick;
      last = 1'b1;
      next_state = state;
      next_cur_ch = cur_ch;
      next_idx = idx;
      next_conv_count = conv_count;
      next_conv_start = 1'b0;
      next_conv_channel = conv_channel;
      next_conv_average = conv_average;
      next_conv_to_fifo = conv_to_fifo;
      next_scan_done = 1'b0;
      if (start_req) begin
         next_idx = 8'h00;
         next_conv_count = 9'h000;
         next_state = asq_pkg::ST_RUN;
         unique case (scan_code)
            asq_pkg::SCAN_ZERO_EXT: next_cur_ch = 4'h0;
            asq_pkg::SCAN_UPPER_INT, asq_pkg::SCAN_UPPER_EXT: begin
               next_cur_ch = chsel;
               if (chsel > TOP) begin
                  next_state = asq_pkg::ST_IDLE;
                  next_scan_done = 1'b1;
               end
            end
            asq_pkg::SCAN_USER_INT, asq_pkg::SCAN_USER_EXT: begin
               next_cur_ch = first_user[3:0];
               if (first_user[4]) begin
                  next_state = asq_pkg::ST_IDLE;
                  next_scan_done = 1'b1;
               end
            end
            asq_pkg::SCAN_LIST_EXT: next_cur_ch = list_mem[8'h00];
            default: begin
               next_state = asq_pkg::ST_IDLE;
               next_scan_done = 1'b1;
            end
         endcase
      end else if ((state == asq_pkg::ST_RUN) && pace) begin
         next_conv_start = 1'b1;
         next_conv_channel = cur_ch;
         next_conv_to_fifo = !is_ext(scan_code);
         next_conv_average = !is_ext(scan_code) && avg_on;
         next_conv_count = conv_count + 9'h001;
         unique case (scan_code)
            asq_pkg::SCAN_ZERO_EXT: begin
               last = (cur_ch == chsel) || (cur_ch == TOP);
               next_cur_ch = cur_ch + 4'h1;
            end
            asq_pkg::SCAN_UPPER_INT, asq_pkg::SCAN_UPPER_EXT: begin
               last = (cur_ch == TOP);
               next_cur_ch = cur_ch + 4'h1;
            end
            asq_pkg::SCAN_USER_INT, asq_pkg::SCAN_USER_EXT: begin
               last = succ_user[4];
               next_cur_ch = succ_user[3:0];
            end
            asq_pkg::SCAN_LIST_EXT: begin
               last = (idx == list_len);
               next_idx = idx + 8'h01;
               next_cur_ch = list_mem[idx + 8'h01];
            end
            default: last = 1'b1;
         endcase
         if (last) begin
            next_state = asq_pkg::ST_IDLE;
            next_scan_done = 1'b1;
         end
      end
      next_scan_busy = (next_state == asq_pkg::ST_RUN);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= asq_pkg::ST_IDLE;
         cur_ch <= 4'h0;
         idx <= 8'h00;
         conv_count <= 9'h000;
         conv_start <= 1'b0;
         conv_channel <= 4'h0;
         conv_average <= 1'b0;
         conv_to_fifo <= 1'b0;
         scan_busy <= 1'b0;
         scan_done <= 1'b0;
      end else begin
         state <= next_state;
         cur_ch <= next_cur_ch;
         idx <= next_idx;
         conv_count <= next_conv_count;
         conv_start <= next_conv_start;
         conv_channel <= next_conv_channel;
         conv_average <= next_conv_average;
         conv_to_fifo <= next_conv_to_fifo;
         scan_busy <= next_scan_busy;
         scan_done <= next_scan_done;
      end
   end
endmodule // asq_sequencer

//--- bench/asq_host_model.sv
`timescale 1ns/10ps
module asq_host_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic step_req,
   output logic ext_step,
   output logic host_idle
);
   logic [3:0] cnt;
   // Host pacing: 4 cycles high, 9 low, repeated while asked
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         cnt <= 4'h0;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
      else if (step_req)
         cnt <= 4'hc;
   end
   assign ext_step = cnt > 4'h8;
   assign host_idle = cnt == 4'h0;
endmodule // asq_host_model

//--- bench/asq_checker.sv
`timescale 1ns/10ps
module asq_checker #(
   parameter int NUM_CH = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [15:0] reg_rdata,
   input wire logic ext_step,
   input wire logic conv_start,
   input wire logic [3:0] conv_channel,
   input wire logic conv_average,
   input wire logic conv_to_fifo,
   input wire logic scan_busy,
   input wire logic scan_done
);
   logic [3:0] code;
   logic [3:0] n;
   logic [3:0] next_code;
   logic [3:0] next_n;
   logic mode_wr;
   logic keep_wr;
   assign mode_wr = reg_write && reg_addr == asq_pkg::REG_MODE;
   assign keep_wr = mode_wr && (reg_wdata[14:11] == 4'h0 ||
      reg_wdata[14:11] >= 4'ha);
   // Follow the last accepted scan code and channel select
   always_comb begin
      next_code = code;
      next_n = n;
      if (mode_wr && !keep_wr) begin
         next_code = reg_wdata[14:11];
         next_n = reg_wdata[10:7];
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         code <= 4'h0;
         n <= 4'h0;
      end else begin
         code <= next_code;
         n <= next_n;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   read_idle_a: assert property (!reg_read |=> reg_rdata == 16'h0)
      else $error("read data not zero outside read answer");
   done_pulse_a: assert property (scan_done |-> !scan_busy ##1 !scan_done)
      else $error("scan done not a single pulse");
   start_busy_a: assert property (conv_start |-> scan_busy || scan_done)
      else $error("conversion outside a scan");
   scan_begin_a: assert property (mode_wr && !keep_wr |-> ##2
      (scan_busy || scan_done)) else $error("scan did not begin");
   keep_mode_a: assert property (keep_wr && !scan_busy |=>
      (!scan_busy && !scan_done) [*3]) else $error("keep code restarted");
   fifo_route_a: assert property (conv_start |-> conv_to_fifo ==
      (code == 4'h5 || code == 4'h7)) else $error("result routing wrong");
   ext_noavg_a: assert property (conv_start && !conv_to_fifo |->
      !conv_average) else $error("averaging in host-paced mode");
   upper_range_a: assert property (conv_start && (code == 4'h5 ||
      code == 4'h6) |-> conv_channel >= n && conv_channel < NUM_CH)
      else $error("upper sweep channel out of range");
   zero_range_a: assert property (conv_start && code == 4'h4 |->
      conv_channel <= n) else $error("zero sweep channel above select");
endmodule // asq_checker
bind asq_sequencer asq_checker #(.NUM_CH(NUM_CH)) i_chk (.clk_sys, .rst,
   .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .ext_step,
   .conv_start, .conv_channel, .conv_average, .conv_to_fifo, .scan_busy,
   .scan_done);

//--- bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic step_req = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0;
   logic [15:0] reg_rdata;
   logic [15:0] rd_val;
   logic [3:0] conv_channel;
   logic ext_step, conv_start, conv_average, conv_to_fifo;
   logic scan_busy, scan_done, host_idle;
   int error_cnt = 0;
   int total_checks = 0;
   int done_cnt = 0;
   int cyc = 0;
   logic [15:0] got_q[$];
   logic [15:0] exp_q[$];
   always #4 clk_sys = ~clk_sys;
   asq_sequencer #(.NUM_CH(16), .INT_DIV(2)) i_dut (.clk_sys, .rst,
      .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .ext_step,
      .conv_start, .conv_channel, .conv_average, .conv_to_fifo, .scan_busy,
      .scan_done);
   asq_host_model i_host (.clk_sys, .rst, .step_req, .ext_step, .host_idle);
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Record conversions with flags, count scan ends, cut hangs
   always @(posedge clk_sys) begin
      cyc++;
      if (conv_start === 1'b1)
         got_q.push_back({10'h0, conv_to_fifo, conv_average, conv_channel});
      if (scan_done === 1'b1)
         done_cnt++;
      if (cyc == 60000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      @(negedge clk_sys);
      rd_val = reg_rdata;
   endtask
   // Expected conversions of the sweep and user-list modes
   function automatic void build(input logic [3:0] code, n, input logic avg,
      input logic [15:0] mask);
      logic fi;
      fi = code == 4'h5 || code == 4'h7;
      exp_q.delete();
      for (int c = 0; c < 16; c++)
         if ((code == 4'h4 && c <= n) || ((code == 4'h5 || code == 4'h6)
            && c >= n) || ((code == 4'h7 || code == 4'h8) && mask[c]))
            exp_q.push_back({10'h0, fi, fi & avg, 4'(c)});
   endfunction
   // Start one scan, pace it if host-paced, compare all conversions
   task automatic run(input logic [3:0] code, n, input logic avg);
      int d0;
      int i;
      d0 = done_cnt;
      got_q.delete();
      wr(asq_pkg::REG_CONFIG, {15'h0, avg});
      wr(asq_pkg::REG_MODE, {1'b0, code, n, 7'h0});
      step_req <= code inside {4'h4, 4'h6, 4'h8, 4'h9};
      i = 0;
      while (done_cnt == d0 && i < 5000) begin
         @(posedge clk_sys);
         i++;
      end
      step_req <= 1'b0;
      do @(posedge clk_sys); while (!host_idle);
      repeat (16) @(posedge clk_sys);
      chk("scan end", 16'h1, 16'(done_cnt - d0));
      chk("count", 16'(exp_q.size()), 16'(got_q.size()));
      rd(asq_pkg::REG_COUNT);
      chk("conv count", 16'(exp_q.size()), rd_val);
      foreach (exp_q[k])
         chk("conversion", exp_q[k], got_q[k]);
      $display("Test scan code %h done", code);
   endtask
   initial begin
      logic [15:0] mask;
      logic [3:0] n;
      logic [3:0] lst[5];
      logic [3:0] codes[3];
      void'($urandom(32'h2ca9));
      codes = '{4'h4, 4'h5, 4'h6};
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      rd(asq_pkg::REG_STATUS);
      chk("status reset", 16'h0, rd_val);
      rd(4'hf);
      chk("unmapped", 16'h0, rd_val);
      build(4'h5, 4'he, 1'b1, 16'h0);
      run(4'h5, 4'he, 1'b1);
      repeat (4) begin
         n = 4'($urandom);
         foreach (codes[c]) begin
            build(codes[c], n, 1'b1, 16'h0);
            run(codes[c], n, 1'b1);
         end
      end
      foreach (lst[i]) begin
         mask = (i == 0) ? 16'h0 : (i == 1) ? 16'hffff : 16'($urandom);
         wr(asq_pkg::REG_USER_LOW, {8'h0, mask[7:0]});
         wr(asq_pkg::REG_USER_HIGH, {8'h0, mask[15:8]});
         build(4'h7, 4'h3, 1'b1, mask);
         run(4'h7, 4'h3, 1'b1);
         build(4'h8, 4'h3, 1'b1, mask);
         run(4'h8, 4'h3, 1'b1);
      end
      // Arbitrary list with a repeat, random other entries and an entry readback
      wr(asq_pkg::REG_LIST_PTR, 16'h0);
      exp_q.delete();
      foreach (lst[i]) begin
         lst[i] = (i == 3) ? lst[1] : 4'($urandom);
         wr(asq_pkg::REG_LIST_DATA, {12'h0, lst[i]});
         exp_q.push_back({12'h0, lst[i]});
      end
      wr(asq_pkg::REG_LIST_LEN, 16'h4);
      wr(asq_pkg::REG_LIST_PTR, 16'h2);
      rd(asq_pkg::REG_LIST_DATA);
      chk("list entry", {12'h0, lst[2]}, rd_val);
      run(4'h9, 4'h0, 1'b1);
      // Keep codes leave the list mode in place
      foreach (lst[i]) begin
         n = (i == 0) ? 4'h0 : 4'ha + 4'(i);
         wr(asq_pkg::REG_MODE, {1'b0, n, 11'h7ff});
         rd(asq_pkg::REG_STATUS);
         chk("kept code", 16'h9, {12'h0, rd_val[4:1]});
         rd(asq_pkg::REG_MODE);
         chk("kept select", 16'h4800, rd_val);
      end
      wr(asq_pkg::REG_MODE, {1'b0, 4'ha, 11'h0});
      rd(asq_pkg::REG_STATUS);
      chk("kept code", 16'h9, {12'h0, rd_val[4:1]});
      $display("Test keep codes done");
      end_of_test();
   end
endmodule // tb_top
